// ### inc/etk_consts.vh
// Constants of the ECC error tracking block: opcodes, register
// addresses, field positions, widths and reset values.
// Definitions only; included by the design files by bare name.
`ifndef ETK_CONSTS_VH
`define ETK_CONSTS_VH

// Serial opcodes
`define ETK_OP_READ_ANY_REG 8'h65
`define ETK_OP_UNIT_STATUS 8'h19
`define ETK_OP_STATE_CLEAR 8'h1B

// Read-any-register addresses, one byte per address
`define ETK_RA_STATUS 24'h000010
`define ETK_RA_CNT_LO 24'h000020
`define ETK_RA_CNT_HI 24'h000021
`define ETK_RA_TRAP_B0 24'h000030
`define ETK_RA_TRAP_B1 24'h000031
`define ETK_RA_TRAP_B2 24'h000032
`define ETK_RA_TRAP_B3 24'h000033

// Field layout and reset values
`define ETK_FLAG_BIT 4
`define ETK_UNIT_LSB 3
`define ETK_ADDR_W 24
`define ETK_CNT_W 16
`define ETK_TRAP_W 32
`define ETK_CNT_RST 16'h0000
`define ETK_CNT_MAX 16'hFFFF
`define ETK_TRAP_RST 32'h00000000

// Error classes reported by the array read checker
`define ETK_NERR_NONE 2'h0
`define ETK_NERR_TWO 2'h2
`define ETK_NERR_THREE 2'h3

// Last bit index of each serial frame part (length in link clocks minus one)
`define ETK_OP_BITS 5'h07
`define ETK_ADDR_BITS 5'h17
`define ETK_BYTE_BITS 3'h7

`endif

// ### rtl/etk_tracker.v
// Error state of the ECC: sticky flag, saturating counter, address trap.
// Events and clears come from logic on the same clock.
`timescale 1ns/1ps
`include "etk_consts.vh"

module etk_tracker #(
  parameter CNT_W = `ETK_CNT_W
) (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // Events
  input wire evt_i,
  input wire [23:0] evt_addr_i,
  input wire clr_i,
  input wire wipe_i,
  // State
  output wire flag_o,
  output wire [CNT_W-1:0] cnt_o,
  output wire [31:0] trap_o
);

  reg flag_reg;
  reg armed_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [31:0] trap_reg;
  wire [CNT_W-1:0] cnt_max;

  assign cnt_max = {CNT_W{1'b1}};

  // Wipe (reset, power down) beats everything; an event with a clear acts as clear then event
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_reg <= 1'b0;
      armed_reg <= 1'b1;
      cnt_reg <= {CNT_W{1'b0}};
      trap_reg <= `ETK_TRAP_RST;
    end else if (wipe_i) begin
      flag_reg <= 1'b0; // R8
      armed_reg <= 1'b1;
      cnt_reg <= {CNT_W{1'b0}}; // R10
      trap_reg <= `ETK_TRAP_RST; // R9
    end else if (evt_i) begin
      flag_reg <= 1'b1; // R11
      armed_reg <= 1'b0;
      if (clr_i) begin
        cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (cnt_reg != cnt_max) begin
        cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1}; // R6 R7
      end
      // Only the first failing unit is kept
      if (armed_reg || clr_i) begin
        trap_reg <= {8'h00, evt_addr_i[23:3], 3'h0}; // R4 R5 R19
      end
    end else if (clr_i) begin
      flag_reg <= 1'b0; // R11 R14
      armed_reg <= 1'b1;
      cnt_reg <= {CNT_W{1'b0}}; // R10
      trap_reg <= `ETK_TRAP_RST; // R14
    end
  end

  assign flag_o = flag_reg;
  assign cnt_o = cnt_reg;
  assign trap_o = trap_reg;

endmodule

// ### rtl/etk_top.v
// ECC error tracking with its serial command front end.
// Assumes a single-lane SPI mode 0 host, much slower than mclk_i, and
// an array read path that reports the error class of each unit read.
//
// Summary of operation
// R1: Every array read checks its whole 8-byte unit for three-bit errors.
// R2: Two-bit errors are written back corrected and never reported.
// R3: Checking is always on; nothing can disable detection or correction.
// R4: Trap keeps unit address of first three-bit error since reset/clear.
// R5: Unit address sits in the three low bytes of the trap.
// R6: Counter adds one per three-bit error on an array read.
// R7: Counter stops at FFFF.
// R8: Counter reads zero after deep power down.
// R9: Trap reads zero after deep power down.
// R10: Counter cleared by any reset; clear command clears it too.
// R11: Status bit 4 sets on three-bit error, clear command resets it.
// R12: Status, counter and trap are read through read-any-register 65h.
// R13: Opcode 19h plus unit address returns that unit's status byte.
// R14: Opcode 1Bh, no address, clears flag, trap and counter.
// R15: Special sector and register reads never touch the error state.
// R16: Host must check flag or counter, since unit zero traps as zero.
// R17: Status read drops address bits 2:0, waits dummies, gives 8 bits.
// R18: Clear command needs no write enable latch.
// R19: Trap address is the read address with bits 2:0 forced to zero.
`timescale 1ns/1ps
`include "etk_consts.vh"

module etk_top #(
  parameter CNT_W = `ETK_CNT_W
) (
  // Clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  // System events
  input wire soft_rst_i,
  input wire deep_power_down_i,
  input wire [3:0] latency_i,
  // Serial pins
  input wire cs_n_i,
  input wire sck_i,
  input wire si_i,
  output wire so_o,
  output wire so_oe_o,
  // Array read results
  input wire rd_valid_i,
  input wire [23:0] rd_addr_i,
  input wire [1:0] rd_nerr_i,
  input wire rd_array_i,
  // Corrected write-back
  output wire wb_req_o,
  output wire [23:0] wb_addr_o,
  // Unit status query to the array
  output wire qry_req_o,
  output wire [23:0] qry_addr_o,
  input wire qry_ack_i,
  input wire qry_err3_i,
  // Error state
  output wire triple_bit_error_flag_o,
  output wire [CNT_W-1:0] ecc_detection_counter_o,
  output wire [31:0] ecc_error_address_trap_o
);

  localparam ST_CMD = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_DATA = 3'h3;
  localparam ST_SKIP = 3'h4;

  // Pin synchronisers: bit 0 cs_n, bit 1 sck, bit 2 si
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  reg [2:0] pin_prev_reg;
  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire sck_rise;
  wire sck_fall;
  wire cs_rise;

  // Serial engine
  reg [2:0] st_reg;
  reg [4:0] bcnt_reg;
  reg [7:0] op_reg;
  reg [23:0] sh_in_reg;
  reg [23:0] addr_reg;
  reg [3:0] dcnt_reg;
  reg [7:0] sh_out_reg;
  reg so_reg;
  reg so_oe_reg;
  reg load_reg;
  reg clr_arm_reg;
  reg clr_reg;
  wire [23:0] addr_full;

  // Query and write-back
  reg qry_req_reg;
  reg [23:0] qry_addr_reg;
  reg qry_flag_reg;
  reg wb_req_reg;
  reg [23:0] wb_addr_reg;

  // Tracker side
  wire evt;
  wire wipe;
  wire flag;
  wire [CNT_W-1:0] cnt;
  wire [31:0] trap;
  wire [15:0] cnt_ext;
  wire [7:0] cnt_b0;
  wire [7:0] cnt_b1;
  wire [7:0] out_byte;

  // Byte seen by read-any-register at one address; unmapped reads zero
  function [7:0] reg_byte;
    input [23:0] a;
    input fl;
    input [7:0] c0;
    input [7:0] c1;
    input [31:0] t;
    begin
      case (a)
        `ETK_RA_STATUS: reg_byte = {3'h0, fl, 4'h0};
        `ETK_RA_CNT_LO: reg_byte = c0;
        `ETK_RA_CNT_HI: reg_byte = c1;
        `ETK_RA_TRAP_B0: reg_byte = t[7:0];
        `ETK_RA_TRAP_B1: reg_byte = t[15:8];
        `ETK_RA_TRAP_B2: reg_byte = t[23:16];
        `ETK_RA_TRAP_B3: reg_byte = t[31:24];
        default: reg_byte = 8'h00;
      endcase
    end
  endfunction

  // The first stage never feeds logic; edges compare the second and third stages
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_meta_reg <= 3'h1;
      pin_sync_reg <= 3'h1;
      pin_prev_reg <= 3'h1;
    end else begin
      pin_meta_reg <= {si_i, sck_i, cs_n_i};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign cs_n_s = pin_sync_reg[0];
  assign sck_s = pin_sync_reg[1];
  assign si_s = pin_sync_reg[2];
  assign sck_rise = !cs_n_s && sck_s && !pin_prev_reg[1];
  assign sck_fall = !cs_n_s && !sck_s && pin_prev_reg[1];
  assign cs_rise = cs_n_s && !pin_prev_reg[0];
  assign addr_full = {sh_in_reg[22:0], si_s};

  // Status byte for a unit query carries only that unit's flag
  assign out_byte = (op_reg == `ETK_OP_UNIT_STATUS) ?
    {3'h0, qry_flag_reg, 4'h0} :
    reg_byte(addr_reg, flag, cnt_b0, cnt_b1, trap); // R12 R13

  // Counter seen as its two register bytes whatever CNT_W is
  generate
    if (CNT_W >= 16) begin : g_cnt_wide
      assign cnt_ext = cnt[15:0];
    end else begin : g_cnt_narrow
      assign cnt_ext = {{(16-CNT_W){1'b0}}, cnt};
    end
  endgenerate

  assign cnt_b0 = cnt_ext[7:0];
  assign cnt_b1 = cnt_ext[15:8];

  // Serial command engine; bits in on rising, out on falling sck
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= ST_CMD;
      bcnt_reg <= 5'h00;
      op_reg <= 8'h00;
      sh_in_reg <= 24'h000000;
      addr_reg <= 24'h000000;
      dcnt_reg <= 4'h0;
      sh_out_reg <= 8'h00;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      load_reg <= 1'b0;
      clr_arm_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      clr_reg <= 1'b0;
      if (cs_n_s) begin
        // Clear runs only when the frame ends right after the opcode
        clr_reg <= cs_rise && clr_arm_reg; // R14 R18
        st_reg <= ST_CMD;
        bcnt_reg <= 5'h00;
        dcnt_reg <= 4'h0;
        so_oe_reg <= 1'b0;
        load_reg <= 1'b0;
        clr_arm_reg <= 1'b0;
      end else begin
        case (st_reg)
          ST_CMD: begin
            if (sck_rise) begin
              sh_in_reg <= {sh_in_reg[22:0], si_s};
              bcnt_reg <= bcnt_reg + 5'h01;
              if (bcnt_reg == `ETK_OP_BITS) begin
                op_reg <= {sh_in_reg[6:0], si_s};
                bcnt_reg <= 5'h00;
                case ({sh_in_reg[6:0], si_s})
                  `ETK_OP_READ_ANY_REG: st_reg <= ST_ADDR;
                  `ETK_OP_UNIT_STATUS: st_reg <= ST_ADDR;
                  `ETK_OP_STATE_CLEAR: begin
                    st_reg <= ST_SKIP;
                    clr_arm_reg <= 1'b1; // R14
                  end
                  default: st_reg <= ST_SKIP;
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (sck_rise) begin
              sh_in_reg <= addr_full;
              bcnt_reg <= bcnt_reg + 5'h01;
              if (bcnt_reg == `ETK_ADDR_BITS) begin
                bcnt_reg <= 5'h00;
                if (op_reg == `ETK_OP_UNIT_STATUS) begin
                  addr_reg <= {addr_full[23:3], 3'h0}; // R17
                end else begin
                  addr_reg <= addr_full;
                end
                if (latency_i == 4'h0) begin
                  st_reg <= ST_DATA;
                  load_reg <= 1'b1;
                end else begin
                  st_reg <= ST_DUMMY;
                end
              end
            end
          end
          ST_DUMMY: begin
            // Gives the array time to answer a unit query
            if (sck_rise) begin
              dcnt_reg <= dcnt_reg + 4'h1;
              if (dcnt_reg == latency_i - 4'h1) begin
                st_reg <= ST_DATA; // R17
                load_reg <= 1'b1;
              end
            end
          end
          ST_DATA: begin
            if (sck_fall) begin
              so_oe_reg <= 1'b1;
              if (load_reg) begin
                so_reg <= out_byte[7];
                sh_out_reg <= {out_byte[6:0], 1'b0};
                load_reg <= 1'b0;
              end else begin
                so_reg <= sh_out_reg[7];
                sh_out_reg <= {sh_out_reg[6:0], 1'b0};
              end
            end
            if (sck_rise) begin
              bcnt_reg <= bcnt_reg + 5'h01;
              if (bcnt_reg[2:0] == `ETK_BYTE_BITS) begin
                bcnt_reg <= 5'h00;
                if (op_reg == `ETK_OP_UNIT_STATUS) begin
                  // Past the status byte the host gets zeros
                  st_reg <= ST_SKIP; // R17
                end else begin
                  addr_reg <= addr_reg + 24'h000001;
                  load_reg <= 1'b1;
                end
              end
            end
          end
          ST_SKIP: begin
            if (sck_rise) begin
              clr_arm_reg <= 1'b0;
            end
            if (sck_fall) begin
              so_reg <= 1'b0;
            end
          end
          default: st_reg <= ST_CMD;
        endcase
      end
    end
  end

  // Unit query: request held until the array acknowledges
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      qry_req_reg <= 1'b0;
      qry_addr_reg <= 24'h000000;
      qry_flag_reg <= 1'b0;
    end else begin
      if (st_reg == ST_ADDR && sck_rise && !cs_n_s &&
          bcnt_reg == `ETK_ADDR_BITS &&
          op_reg == `ETK_OP_UNIT_STATUS) begin
        qry_req_reg <= 1'b1;
        qry_addr_reg <= {addr_full[23:3], 3'h0}; // R13 R17
        qry_flag_reg <= 1'b0;
      end else if (qry_req_reg && qry_ack_i) begin
        qry_req_reg <= 1'b0;
        qry_flag_reg <= qry_err3_i; // R13
      end
    end
  end

  // Checker result per array read; no switch can mask it
  assign evt = rd_valid_i && rd_array_i &&
    rd_nerr_i == `ETK_NERR_THREE; // R1 R3 R15
  assign wipe = soft_rst_i || deep_power_down_i; // R8 R9 R10

  // Corrected unit goes back in the refresh, silently
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wb_req_reg <= 1'b0;
      wb_addr_reg <= 24'h000000;
    end else begin
      wb_req_reg <= rd_valid_i && rd_array_i &&
        rd_nerr_i != `ETK_NERR_NONE &&
        rd_nerr_i != `ETK_NERR_THREE; // R2
      if (rd_valid_i) begin
        wb_addr_reg <= {rd_addr_i[23:3], 3'h0}; // R2
      end
    end
  end

  etk_tracker #(
    .CNT_W(CNT_W)
  ) u_tracker (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .evt_i(evt),
    .evt_addr_i(rd_addr_i),
    .clr_i(clr_reg),
    .wipe_i(wipe),
    .flag_o(flag),
    .cnt_o(cnt),
    .trap_o(trap)
  );

  assign so_o = so_reg;
  assign so_oe_o = so_oe_reg;
  assign wb_req_o = wb_req_reg;
  assign wb_addr_o = wb_addr_reg;
  assign qry_req_o = qry_req_reg;
  assign qry_addr_o = qry_addr_reg;
  assign triple_bit_error_flag_o = flag;
  assign ecc_detection_counter_o = cnt;
  assign ecc_error_address_trap_o = trap;

endmodule

// ### bench/etk_top_assertions.sv
// Checker for the ECC error tracking top: watches its ports only.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
module etk_top_chk #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // System events
  input wire logic soft_rst_i,
  input wire logic deep_power_down_i,
  // Serial and query
  input wire logic cs_n_i,
  input wire logic so_oe_o,
  input wire logic qry_req_o,
  input wire logic qry_ack_i,
  input wire logic qry_err3_i,
  // Array reads
  input wire logic rd_valid_i,
  input wire logic [23:0] rd_addr_i,
  input wire logic [1:0] rd_nerr_i,
  input wire logic rd_array_i,
  input wire logic wb_req_o,
  input wire logic [23:0] wb_addr_o,
  // Error state
  input wire logic triple_bit_error_flag_o,
  input wire logic [CNT_W-1:0] ecc_detection_counter_o,
  input wire logic [31:0] ecc_error_address_trap_o
);
  localparam logic [CNT_W-1:0] MAX = '1;
  wire logic ev3;
  wire logic hold;
  wire logic [23:0] unit;
  wire logic [CNT_W-1:0] cnt;
  assign ev3 = rd_valid_i && rd_array_i && rd_nerr_i == 2'h3;
  assign hold = soft_rst_i || deep_power_down_i;
  assign unit = {rd_addr_i[23:3], 3'h0};
  assign cnt = ecc_detection_counter_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  property p_wb;
    rd_valid_i && rd_array_i && (rd_nerr_i == 2'h1 || rd_nerr_i == 2'h2)
      |=> wb_req_o && wb_addr_o == $past(unit);
  endproperty
  a_wb: assert property (p_wb) else $error("no write-back");
  property p_flag;
    ev3 && !hold |=> triple_bit_error_flag_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_inc;
    ev3 && !hold && cnt != MAX |=> cnt == $past(cnt) + 1'b1 || cnt == 1;
  endproperty
  a_inc: assert property (p_inc) else $error("count step");
  property p_sat;
    ev3 && !hold && cnt == MAX |=> cnt == MAX || cnt == 1;
  endproperty
  a_sat: assert property (p_sat) else $error("count wrapped");
  property p_dpd;
    deep_power_down_i |=> cnt == 0 && ecc_error_address_trap_o == 0
      && !triple_bit_error_flag_o;
  endproperty
  a_dpd: assert property (p_dpd) else $error("power down kept");
  property p_rst;
    soft_rst_i |=> cnt == 0 && ecc_error_address_trap_o == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset kept");
  property p_cap;
    ev3 && !hold && !triple_bit_error_flag_o
      |=> ecc_error_address_trap_o == {8'h00, $past(unit)};
  endproperty
  a_cap: assert property (p_cap) else $error("bad trap");
  property p_ign;
    rd_valid_i && !rd_array_i && !hold
      |=> $stable(cnt) && $stable(triple_bit_error_flag_o);
  endproperty
  a_ign: assert property (p_ign) else $error("sector read counted");
  property p_idle;
    cs_n_i [*6] |-> !so_oe_o;
  endproperty
  a_idle: assert property (p_idle) else $error("so driven idle");
  property p_qry;
    qry_req_o && !qry_ack_i |=> qry_req_o;
  endproperty
  a_qry: assert property (p_qry) else $error("query dropped");
  c_sat: cover property (ev3 && cnt == MAX);
  c_qry: cover property (qry_ack_i && qry_err3_i);
  c_dpd: cover property (deep_power_down_i);
endmodule

// ### bench/etk_host.sv
// Host serial controller model: mode 0, MSB first, one lane.
// Clock stands low between frames; so sampled on sck rise.
`timescale 1ns/1ps
module etk_host (
  // Pins
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic clk_bit(input logic b, output logic s);
    sck_o = 1'b0;
    si_o = b;
    #62.5;
    sck_o = 1'b1;
    s = so_i;
    #62.5;
  endtask
  // Opcode, na address bits, nd dummies, nb data bits
  task automatic frame(input logic [7:0] op, input logic [31:0] ad,
      input int na, input int nd, input int nb, output logic [31:0] d);
    logic s;
    d = 32'h0;
    cs_n_o = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) clk_bit(op[i], s);
    for (int i = na - 1; i >= 0; i--) clk_bit(ad[i], s);
    for (int i = 0; i < nd + nb; i++) begin
      clk_bit(~si_o, s);
      if (i >= nd) d = {d[30:0], s};
    end
    sck_o = 1'b0;
    #62.5;
    cs_n_o = 1'b1;
    si_o = ~si_o;
    #250;
  endtask
endmodule

// ### bench/tb.sv
// Bench for the ECC error tracking top with the host model.
// Counter shortened to 4 bits so saturation is reached quickly.
`timescale 1ns/1ps
module tb;
  localparam int CW = 4;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic soft_rst_i = 1'b0;
  logic deep_power_down_i = 1'b0;
  logic [3:0] latency_i = 4'h2;
  logic rd_valid_i = 1'b0;
  logic [23:0] rd_addr_i = 24'h0;
  logic [1:0] rd_nerr_i = 2'h0;
  logic rd_array_i = 1'b0;
  logic qry_ack_i = 1'b0;
  logic qry_err3_i = 1'b0;
  wire logic cs_n_i, sck_i, si_i, so_o, so_oe_o, wb_req_o, qry_req_o;
  wire logic flag_o;
  wire logic [23:0] wb_addr_o, qry_addr_o;
  wire logic [CW-1:0] cnt_o;
  wire logic [31:0] trap_o;
  logic [31:0] got, e, trap;
  logic [31:0] exp_q[$];
  logic [23:0] a, qexp;
  logic [CW-1:0] cnt;
  logic fl, qerr;
  integer seed = 30;
  int num_errors = 0;
  int n_compared = 0;
  event got_ev;
  etk_top #(.CNT_W(CW)) i_etk_top (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst_i),
    .deep_power_down_i(deep_power_down_i), .latency_i(latency_i),
    .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .rd_valid_i(rd_valid_i), .rd_addr_i(rd_addr_i),
    .rd_nerr_i(rd_nerr_i), .rd_array_i(rd_array_i), .wb_req_o(wb_req_o),
    .wb_addr_o(wb_addr_o), .qry_req_o(qry_req_o), .qry_addr_o(qry_addr_o),
    .qry_ack_i(qry_ack_i), .qry_err3_i(qry_err3_i),
    .triple_bit_error_flag_o(flag_o), .ecc_detection_counter_o(cnt_o),
    .ecc_error_address_trap_o(trap_o));
  // Undriven so line reads inverted, so a late enable corrupts data
  etk_host i_etk_host (
    .cs_n_o(cs_n_i), .sck_o(sck_i), .si_o(si_i),
    .so_i(so_oe_o ? so_o : ~so_o));
  initial forever #5 mclk_i = ~mclk_i;
  // Array side answers each unit query one cycle later
  always @(negedge mclk_i) begin
    if (qry_ack_i) begin
      qry_ack_i <= 1'b0;
      qry_err3_i <= ~qry_err3_i;
    end else if (qry_req_o) begin
      qry_ack_i <= 1'b1;
      qry_err3_i <= qerr;
      n_compared++;
      if (qry_addr_o !== qexp) begin
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
          qry_addr_o, qexp);
        num_errors++;
      end
    end
  end
  always @(got_ev) begin
    e = exp_q.pop_front();
    n_compared++;
    if (got !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
      num_errors++;
    end
  end
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic rd(input logic [23:0] ad, input int nb, input logic [31:0] x);
    exp_q.push_back(x);
    i_etk_host.frame(8'h65, {8'h0, ad}, 24, latency_i, nb, got);
    ->got_ev;
  endtask
  task automatic chk();
    rd(24'h000010, 8, {24'h0, 3'h0, fl, 4'h0});
    rd(24'h000020, 16, {16'h0, 8'(cnt), 8'h00});
    rd(24'h000030, 32, {trap[7:0], trap[15:8], trap[23:16], trap[31:24]});
  endtask
  task automatic qry(input logic [23:0] ad, input logic q);
    qerr = q;
    qexp = {ad[23:3], 3'h0};
    exp_q.push_back({24'h0, 3'h0, q, 4'h0});
    i_etk_host.frame(8'h19, {8'h0, ad}, 24, latency_i, 8, got);
    ->got_ev;
  endtask
  task automatic ev(input logic [23:0] ad, input logic [1:0] n, input logic ar);
    @(negedge mclk_i);
    rd_valid_i = 1'b1;
    rd_addr_i = ad;
    rd_nerr_i = n;
    rd_array_i = ar;
    if (ar && n == 2'h3) begin
      if (!fl) trap = {8'h00, ad[23:3], 3'h0};
      fl = 1'b1;
      if (cnt != '1) cnt = cnt + 1'b1;
    end
  endtask
  task automatic idle();
    @(negedge mclk_i);
    rd_valid_i = 1'b0;
  endtask
  task automatic zero();
    fl = 1'b0;
    cnt = '0;
    trap = 32'h0;
  endtask
  initial begin
    #1ms;
    num_errors++;
    final_report();
  end
  initial begin
    latency_i = 4'h2 + 4'($random(seed) & 7);
    zero();
    repeat (6) @(negedge mclk_i);
    arst_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk();
    rd(24'h000040, 8, 32'h0);
    a = 24'($random(seed));
    ev(a ^ 24'h7, 2'h1, 1'b1);
    ev(a ^ 24'h6, 2'h2, 1'b1);
    ev(a, 2'h3, 1'b0);
    ev({21'h0, a[2:0]}, 2'h3, 1'b1);
    ev(a, 2'h3, 1'b1);
    idle();
    chk();
    qry(a, 1'b1);
    qry(a ^ 24'h5, 1'b0);
    // Extra clocks after the clear opcode cancel it
    i_etk_host.frame(8'h1B, 32'h0, 8, 0, 0, got);
    chk();
    i_etk_host.frame(8'h1B, 32'h0, 0, 0, 0, got);
    zero();
    chk();
    repeat (20) ev(24'($random(seed)), 2'h3, 1'b1);
    idle();
    chk();
    for (int k = 0; k < 2; k++) begin
      ev(24'($random(seed)), 2'h3, 1'b1);
      idle();
      soft_rst_i = (k == 0);
      deep_power_down_i = (k == 1);
      @(negedge mclk_i);
      soft_rst_i = 1'b0;
      deep_power_down_i = 1'b0;
      zero();
      chk();
    end
    final_report();
  end
endmodule
bind etk_top etk_top_chk #(.CNT_W(CNT_W)) i_etk_top_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .soft_rst_i(soft_rst_i),
  .deep_power_down_i(deep_power_down_i), .cs_n_i(cs_n_i),
  .so_oe_o(so_oe_o), .qry_req_o(qry_req_o), .qry_ack_i(qry_ack_i),
  .qry_err3_i(qry_err3_i), .rd_valid_i(rd_valid_i), .rd_addr_i(rd_addr_i),
  .rd_nerr_i(rd_nerr_i), .rd_array_i(rd_array_i), .wb_req_o(wb_req_o),
  .wb_addr_o(wb_addr_o), .triple_bit_error_flag_o(triple_bit_error_flag_o),
  .ecc_detection_counter_o(ecc_detection_counter_o),
  .ecc_error_address_trap_o(ecc_error_address_trap_o));
